// [core/pmp_params.svh]
`ifndef PMP_PARAMS_SVH
`define PMP_PARAMS_SVH

// Register offsets on the plain register port.
`define PMP_OFS_A_LATCH   8'h00
`define PMP_OFS_A_DIR     8'h01
`define PMP_OFS_B_LATCH   8'h02
`define PMP_OFS_B_DIR     8'h03
`define PMP_OFS_C_LATCH   8'h04
`define PMP_OFS_C_DIR     8'h05
`define PMP_OFS_D_LATCH   8'h06
`define PMP_OFS_D_DIR     8'h07
`define PMP_OFS_E_PINS    8'h08
`define PMP_OFS_F_LATCH   8'h09
`define PMP_OFS_F_DIR     8'h0A
`define PMP_OFS_G_LATCH   8'h0B
`define PMP_OFS_G_DIR     8'h0C
`define PMP_OFS_H_LATCH   8'h0D
`define PMP_OFS_H_DIR     8'h0E
`define PMP_OFS_OPTION    8'h0F
`define PMP_OFS_PULL_H    8'h10
`define PMP_OFS_PULL_BFG  8'h11
`define PMP_OFS_MODE      8'h12

// Field positions.
`define PMP_OPT_OPEN_DRAIN_BIT 0
`define PMP_PULL_B_BIT         0
`define PMP_PULL_F_BIT         1
`define PMP_PULL_G_BIT         2
`define PMP_RW_BIT             7

// Reset values.
`define PMP_RST_BYTE  8'h00
`define PMP_RST_SIX   6'h00
`define PMP_RST_PULL  3'h0

`endif

// [core/pmp_pkg.sv]
package pmp_pkg;

    // Operating mode, one-hot; codes from the two mode-select inputs (high, low).
    typedef enum logic [3:0] {
        PMP_MODE_BOOT   = 4'h1,
        PMP_MODE_TEST   = 4'h2,
        PMP_MODE_SINGLE = 4'h4,
        PMP_MODE_EXPAND = 4'h8
    } pmp_mode_type;

endpackage : pmp_pkg

// [core/pmp_port_logic.sv]
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "pmp_params.svh"

module pmp_port_logic #(
    parameter int         PW             = 8,
    parameter int         DW             = 6,
    parameter logic [3:0] H_LOW_PULLUP   = 4'h0
) (
    input  wire logic          core_clk_i,
    input  wire logic          sys_rst_i,
    // Mode-select inputs, sampled while reset is high.
    input  wire logic          mode_select_low_i,
    input  wire logic          mode_select_high_i,
    // Register port.
    input  wire logic [7:0]    reg_addr_i,
    input  wire logic [7:0]    reg_wdata_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    output logic      [7:0]    reg_rdata_o,
    // Expansion bus from the core.
    input  wire logic [15:0]   bus_addr_i,
    input  wire logic [7:0]    bus_wdata_i,
    input  wire logic          bus_read_i,
    input  wire logic          bus_active_i,
    output logic      [7:0]    bus_rdata_o,
    output logic               expanded_o,
    // Port A with timer functions.
    input  wire logic [PW-1:0] port_a_pin_i,
    output logic      [PW-1:0] port_a_pin_o,
    output logic      [PW-1:0] port_a_pin_oe_o,
    input  wire logic [PW-1:0] port_a_alt_en_i,
    input  wire logic [PW-1:0] port_a_alt_out_i,
    input  wire logic [PW-1:0] port_a_alt_oe_i,
    output logic      [PW-1:0] port_a_alt_in_o,
    // Port B.
    input  wire logic [PW-1:0] port_b_pin_i,
    output logic      [PW-1:0] port_b_pin_o,
    output logic      [PW-1:0] port_b_pin_oe_o,
    output logic               port_b_pull_en_o,
    // Port C.
    input  wire logic [PW-1:0] port_c_pin_i,
    output logic      [PW-1:0] port_c_pin_o,
    output logic      [PW-1:0] port_c_pin_oe_o,
    // Port D with serial and SPI functions.
    input  wire logic [DW-1:0] port_d_pin_i,
    output logic      [DW-1:0] port_d_pin_o,
    output logic      [DW-1:0] port_d_pin_oe_o,
    input  wire logic [DW-1:0] port_d_alt_en_i,
    input  wire logic [DW-1:0] port_d_alt_out_i,
    input  wire logic [DW-1:0] port_d_alt_oe_i,
    output logic      [DW-1:0] port_d_alt_in_o,
    // Port E, input only.
    input  wire logic [PW-1:0] port_e_pin_i,
    output logic      [PW-1:0] port_e_adc_o,
    // Port F.
    input  wire logic [PW-1:0] port_f_pin_i,
    output logic      [PW-1:0] port_f_pin_o,
    output logic      [PW-1:0] port_f_pin_oe_o,
    output logic               port_f_pull_en_o,
    // Port G; bit 7 is the shared direction pin.
    input  wire logic [PW-1:0] port_g_pin_i,
    output logic      [PW-1:0] port_g_pin_o,
    output logic      [PW-1:0] port_g_pin_oe_o,
    output logic               port_g_pull_en_o,
    // Port H with serial and PWM functions.
    input  wire logic [PW-1:0] port_h_pin_i,
    output logic      [PW-1:0] port_h_pin_o,
    output logic      [PW-1:0] port_h_pin_oe_o,
    input  wire logic [PW-1:0] port_h_alt_en_i,
    input  wire logic [PW-1:0] port_h_alt_out_i,
    input  wire logic [PW-1:0] port_h_alt_oe_i,
    output logic      [PW-1:0] port_h_alt_in_o,
    output logic      [PW-1:0] port_h_pull_en_o,
    output logic      [PW-1:0] port_h_pull_up_o
);

    // Read-back: output bits return the driver input, input bits the pin.
    function automatic logic [7:0] read_back(input logic [7:0] dir_out,
                                             input logic [7:0] drv,
                                             input logic [7:0] pin);
        read_back = (dir_out & drv) | (~dir_out & pin);
    endfunction : read_back

    pmp_pkg::pmp_mode_type mode;
    logic [PW-1:0]         port_a_latch;
    logic [PW-1:0]         port_a_direction;
    logic [PW-1:0]         port_b_latch;
    logic [PW-1:0]         port_b_direction;
    logic [PW-1:0]         port_c_latch;
    logic [PW-1:0]         port_c_direction;
    logic [DW-1:0]         port_d_latch;
    logic [DW-1:0]         port_d_direction;
    logic [PW-1:0]         port_f_latch;
    logic [PW-1:0]         port_f_direction;
    logic [PW-1:0]         port_g_latch;
    logic [PW-1:0]         port_g_direction;
    logic [PW-1:0]         port_h_latch;
    logic [PW-1:0]         port_h_direction;
    logic                  port_c_open_drain;
    logic [PW-1:0]         pull_assignment_register;
    logic [2:0]            pull_bfg;
    logic [7:0]            rdata;
    logic [PW-1:0]         port_e_sample;

    // Mode decode.
    wire gpio_mode   = (mode == pmp_pkg::PMP_MODE_SINGLE) ||
                       (mode == pmp_pkg::PMP_MODE_BOOT);
    wire single_mode = (mode == pmp_pkg::PMP_MODE_SINGLE);
    wire bus_mode    = ~gpio_mode;

    // Mode capture: the pins are followed for as long as reset is held, so the
    // level present at the last reset edge is the one kept.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            unique case ({mode_select_high_i, mode_select_low_i})
                2'b00:   mode <= pmp_pkg::PMP_MODE_BOOT;
                2'b01:   mode <= pmp_pkg::PMP_MODE_TEST;
                2'b10:   mode <= pmp_pkg::PMP_MODE_SINGLE;
                default: mode <= pmp_pkg::PMP_MODE_EXPAND;
            endcase
        end
    end

    // Write decode.
    wire wr_a_l  = reg_wr_i && (reg_addr_i == `PMP_OFS_A_LATCH);
    wire wr_a_d  = reg_wr_i && (reg_addr_i == `PMP_OFS_A_DIR);
    wire wr_b_l  = reg_wr_i && (reg_addr_i == `PMP_OFS_B_LATCH);
    wire wr_b_d  = reg_wr_i && (reg_addr_i == `PMP_OFS_B_DIR);
    wire wr_c_l  = reg_wr_i && (reg_addr_i == `PMP_OFS_C_LATCH);
    wire wr_c_d  = reg_wr_i && (reg_addr_i == `PMP_OFS_C_DIR);
    wire wr_d_l  = reg_wr_i && (reg_addr_i == `PMP_OFS_D_LATCH);
    wire wr_d_d  = reg_wr_i && (reg_addr_i == `PMP_OFS_D_DIR);
    wire wr_f_l  = reg_wr_i && (reg_addr_i == `PMP_OFS_F_LATCH);
    wire wr_f_d  = reg_wr_i && (reg_addr_i == `PMP_OFS_F_DIR);
    wire wr_g_l  = reg_wr_i && (reg_addr_i == `PMP_OFS_G_LATCH);
    wire wr_g_d  = reg_wr_i && (reg_addr_i == `PMP_OFS_G_DIR);
    wire wr_h_l  = reg_wr_i && (reg_addr_i == `PMP_OFS_H_LATCH);
    wire wr_h_d  = reg_wr_i && (reg_addr_i == `PMP_OFS_H_DIR);
    wire wr_opt  = reg_wr_i && (reg_addr_i == `PMP_OFS_OPTION);
    wire wr_ph   = reg_wr_i && (reg_addr_i == `PMP_OFS_PULL_H);
    wire wr_pbfg = reg_wr_i && (reg_addr_i == `PMP_OFS_PULL_BFG);

    // Latches, directions and options; all clear at reset so every pin left to its direction bit floats.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            port_a_latch             <= `PMP_RST_BYTE;
            port_a_direction         <= `PMP_RST_BYTE;
            port_b_latch             <= `PMP_RST_BYTE;
            port_b_direction         <= `PMP_RST_BYTE;
            port_c_latch             <= `PMP_RST_BYTE;
            port_c_direction         <= `PMP_RST_BYTE;
            port_d_latch             <= `PMP_RST_SIX;
            port_d_direction         <= `PMP_RST_SIX;
            port_f_latch             <= `PMP_RST_BYTE;
            port_f_direction         <= `PMP_RST_BYTE;
            port_g_latch             <= `PMP_RST_BYTE;
            port_g_direction         <= `PMP_RST_BYTE;
            port_h_latch             <= `PMP_RST_BYTE;
            port_h_direction         <= `PMP_RST_BYTE;
            port_c_open_drain        <= 1'b0;
            pull_assignment_register <= `PMP_RST_BYTE;
            pull_bfg                 <= `PMP_RST_PULL;
        end else begin
            if (wr_a_l)  port_a_latch             <= reg_wdata_i;
            if (wr_a_d)  port_a_direction         <= reg_wdata_i;
            if (wr_b_l)  port_b_latch             <= reg_wdata_i;
            if (wr_b_d)  port_b_direction         <= reg_wdata_i;
            if (wr_c_l)  port_c_latch             <= reg_wdata_i;
            if (wr_c_d)  port_c_direction         <= reg_wdata_i;
            if (wr_d_l)  port_d_latch             <= reg_wdata_i[DW-1:0];
            if (wr_d_d)  port_d_direction         <= reg_wdata_i[DW-1:0];
            if (wr_f_l)  port_f_latch             <= reg_wdata_i;
            if (wr_f_d)  port_f_direction         <= reg_wdata_i;
            if (wr_g_l)  port_g_latch             <= reg_wdata_i;
            if (wr_g_d)  port_g_direction         <= reg_wdata_i;
            if (wr_h_l)  port_h_latch             <= reg_wdata_i;
            if (wr_h_d)  port_h_direction         <= reg_wdata_i;
            if (wr_opt)  port_c_open_drain        <= reg_wdata_i[`PMP_OPT_OPEN_DRAIN_BIT];
            if (wr_ph)   pull_assignment_register <= reg_wdata_i;
            if (wr_pbfg) pull_bfg                 <= reg_wdata_i[2:0];
        end
    end

    // Port A: a timer function that owns a pin drives it, so latch writes
    // leave that pin untouched; otherwise the direction bit decides.
    assign port_a_pin_o    = (port_a_alt_en_i & port_a_alt_out_i) |
                             (~port_a_alt_en_i & port_a_latch);
    assign port_a_pin_oe_o = (port_a_alt_en_i & port_a_alt_oe_i) |
                             (~port_a_alt_en_i & port_a_direction);
    assign port_a_alt_in_o = port_a_pin_i;

    // Port B: general I/O in normal-I/O modes, high address byte otherwise.
    assign port_b_pin_o    = bus_mode ? bus_addr_i[15:8] : port_b_latch;
    assign port_b_pin_oe_o = bus_mode ? {PW{1'b1}} :
                             (port_b_direction & {PW{gpio_mode}});

    // Port C: data bus in expanded modes, driven only while a write runs.
    // In single chip mode open drain keeps the high-side off, so a one floats for the pull-up.
    wire bus_drive_c = bus_active_i & ~bus_read_i;
    wire c_od        = port_c_open_drain & single_mode;
    assign port_c_pin_o    = bus_mode ? bus_wdata_i : port_c_latch;
    assign port_c_pin_oe_o = bus_mode ? {PW{bus_drive_c}} :
                             (port_c_direction &
                              ~({PW{c_od}} & port_c_latch));
    assign bus_rdata_o     = port_c_pin_i;

    // Port D: latch drives only pins that no serial function has taken.
    assign port_d_pin_o    = (port_d_alt_en_i & port_d_alt_out_i) |
                             (~port_d_alt_en_i & port_d_latch);
    assign port_d_pin_oe_o = (port_d_alt_en_i & port_d_alt_oe_i) |
                             (~port_d_alt_en_i & port_d_direction);
    assign port_d_alt_in_o = port_d_pin_i;

    // Port E: digital read and converter feed; sampled once so the converter
    // sees a stable value for a full cycle.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            port_e_sample <= `PMP_RST_BYTE;
        end else begin
            port_e_sample <= port_e_pin_i;
        end
    end
    assign port_e_adc_o = port_e_sample;

    // Port F: general I/O or low address byte.
    assign port_f_pin_o    = bus_mode ? bus_addr_i[7:0] : port_f_latch;
    assign port_f_pin_oe_o = bus_mode ? {PW{1'b1}} :
                             (port_f_direction & {PW{gpio_mode}});

    // Port G: bits 6:0 general I/O in normal-I/O modes, input only otherwise; bit 7 carries the bus direction.
    wire [PW-1:0] g_gp_oe = port_g_direction & {PW{gpio_mode}};
    assign port_g_pin_o    = {bus_mode ? bus_read_i : port_g_latch[7],
                              port_g_latch[6:0]};
    assign port_g_pin_oe_o = {bus_mode | g_gp_oe[7], g_gp_oe[6:0]};

    // Port H: serial on 7:4, PWM on 3:0; latch only in normal-I/O modes.
    assign port_h_pin_o    = (port_h_alt_en_i & port_h_alt_out_i) |
                             (~port_h_alt_en_i & port_h_latch);
    assign port_h_pin_oe_o = (port_h_alt_en_i & port_h_alt_oe_i) |
                             (~port_h_alt_en_i & port_h_direction &
                              {PW{gpio_mode}});
    assign port_h_alt_in_o = port_h_pin_i;

    // Pull controls; port H low nibble polarity is a build-time option.
    assign port_b_pull_en_o = pull_bfg[`PMP_PULL_B_BIT];
    assign port_f_pull_en_o = pull_bfg[`PMP_PULL_F_BIT];
    assign port_g_pull_en_o = pull_bfg[`PMP_PULL_G_BIT];
    assign port_h_pull_en_o = pull_assignment_register;
    assign port_h_pull_up_o = {4'hF, H_LOW_PULLUP};
    assign expanded_o       = bus_mode;

    // Read-back per port; the driven flag decides pin or driver input.
    wire [7:0] rb_a = read_back(port_a_pin_oe_o, port_a_pin_o, port_a_pin_i);
    wire [7:0] rb_b = read_back(port_b_pin_oe_o, port_b_pin_o, port_b_pin_i);
    wire [7:0] rb_c = read_back(port_c_pin_oe_o, port_c_pin_o, port_c_pin_i);
    wire [7:0] rb_d = read_back({2'h0, port_d_pin_oe_o}, {2'h0, port_d_pin_o},
                                {2'h0, port_d_pin_i});
    wire [7:0] rb_f = read_back(port_f_pin_oe_o, port_f_pin_o, port_f_pin_i);
    wire [7:0] rb_g = read_back(port_g_pin_oe_o, port_g_pin_o, port_g_pin_i);
    wire [7:0] rb_h = read_back(port_h_pin_oe_o, port_h_pin_o, port_h_pin_i);

    // Read mux; unmapped offsets read zero.
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr_i)
            `PMP_OFS_A_LATCH:  next_rdata = rb_a;
            `PMP_OFS_A_DIR:    next_rdata = port_a_direction;
            `PMP_OFS_B_LATCH:  next_rdata = rb_b;
            `PMP_OFS_B_DIR:    next_rdata = port_b_direction;
            `PMP_OFS_C_LATCH:  next_rdata = rb_c;
            `PMP_OFS_C_DIR:    next_rdata = port_c_direction;
            `PMP_OFS_D_LATCH:  next_rdata = rb_d;
            `PMP_OFS_D_DIR:    next_rdata = {2'h0, port_d_direction};
            `PMP_OFS_E_PINS:   next_rdata = port_e_pin_i;
            `PMP_OFS_F_LATCH:  next_rdata = rb_f;
            `PMP_OFS_F_DIR:    next_rdata = port_f_direction;
            `PMP_OFS_G_LATCH:  next_rdata = rb_g;
            `PMP_OFS_G_DIR:    next_rdata = port_g_direction;
            `PMP_OFS_H_LATCH:  next_rdata = rb_h;
            `PMP_OFS_H_DIR:    next_rdata = port_h_direction;
            `PMP_OFS_OPTION:   next_rdata = {7'h00, port_c_open_drain};
            `PMP_OFS_PULL_H:   next_rdata = pull_assignment_register;
            `PMP_OFS_PULL_BFG: next_rdata = {5'h00, pull_bfg};
            `PMP_OFS_MODE:     next_rdata = {4'h0, mode};
            default:           next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rdata <= 8'h00;
        end else begin
            rdata <= reg_rd_i ? next_rdata : 8'h00;
        end
    end
    assign reg_rdata_o = rdata;

endmodule : pmp_port_logic

// [bench/pmp_port_logic_asserts.sv]
`timescale 1ns/10ps
module pmp_port_logic_asserts #(
    parameter int PW = 8
) (
    input  wire logic          core_clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          reg_rd_i,
    input  wire logic [7:0]    reg_rdata_o,
    input  wire logic [15:0]   bus_addr_i,
    input  wire logic [7:0]    bus_wdata_i,
    input  wire logic          bus_read_i,
    input  wire logic          bus_active_i,
    input  wire logic          expanded_o,
    input  wire logic [PW-1:0] port_a_alt_en_i,
    input  wire logic [PW-1:0] port_a_alt_out_i,
    input  wire logic [PW-1:0] port_a_pin_o,
    input  wire logic [PW-1:0] port_b_pin_o,
    input  wire logic [PW-1:0] port_b_pin_oe_o,
    input  wire logic [PW-1:0] port_c_pin_o,
    input  wire logic [PW-1:0] port_c_pin_oe_o,
    input  wire logic [PW-1:0] port_e_pin_i,
    input  wire logic [PW-1:0] port_e_adc_o,
    input  wire logic [PW-1:0] port_f_pin_o,
    input  wire logic [PW-1:0] port_f_pin_oe_o,
    input  wire logic [PW-1:0] port_g_pin_o,
    input  wire logic [PW-1:0] port_g_pin_oe_o,
    input  wire logic [PW-1:0] port_h_pull_up_o
);
    // One clock domain, so every check shares the clock and pauses in reset.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Bus modes hand ports B, C, F and the shared pin to the expansion bus.
    AST_RW_PIN: assert property (expanded_o |->
        port_g_pin_oe_o[7] && port_g_pin_o[7] == bus_read_i)
        else $error("shared pin does not follow bus direction");
    AST_B_ADDR: assert property (expanded_o |->
        port_b_pin_oe_o == 8'hFF && port_b_pin_o == bus_addr_i[15:8])
        else $error("port B does not carry high address");
    AST_F_ADDR: assert property (expanded_o |->
        port_f_pin_oe_o == 8'hFF && port_f_pin_o == bus_addr_i[7:0])
        else $error("port F does not carry low address");
    AST_C_WRITE: assert property (expanded_o && bus_active_i && !bus_read_i |->
        port_c_pin_oe_o == 8'hFF && port_c_pin_o == bus_wdata_i)
        else $error("port C does not drive write data");
    AST_C_READ: assert property (expanded_o && bus_read_i |-> port_c_pin_oe_o == 8'h00)
        else $error("port C driven during bus read");

    // Read data stand for one cycle only, so an idle cycle is followed by zero.
    AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read answer cycle");
    AST_ADC_COPY: assert property (1'b1 |=> port_e_adc_o == $past(port_e_pin_i))
        else $error("converter inputs do not follow port E");
    AST_OC_OWNS: assert property (
        (port_a_alt_en_i & (port_a_pin_o ^ port_a_alt_out_i)) == '0)
        else $error("port A owned pin not driven by timer");
    AST_H_PULLUP: assert property (port_h_pull_up_o[7:4] == 4'hF)
        else $error("port H upper pulls are not pull-ups");
    // The mode is latched in reset; the pins may wander afterwards.
    AST_MODE_HELD: assert property (!$past(sys_rst_i) |-> $stable(expanded_o))
        else $error("mode changed outside reset");
    AST_B_IN_RST: assert property ($fell(sys_rst_i) && !expanded_o |->
        port_b_pin_oe_o == 8'h00)
        else $error("port B driven right after reset");
endmodule : pmp_port_logic_asserts

bind pmp_port_logic pmp_port_logic_asserts #(.PW(PW)) i_pmp_port_logic_asserts (.*);

// [bench/pmp_pin_model.sv]
`timescale 1ns/10ps
// Outside world of the pins: a line shows the core's value while the core drives it,
// otherwise what external parts put on it; no line is left to the simulator's choice.
module pmp_pin_model #(
    parameter int W = 54
) (
    input  wire logic [W-1:0] out_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] pin_o
);
    // Wired per bit, so the open-drain high level comes from the outside value.
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : pmp_pin_model

// [bench/pmp_port_logic_test.sv]
`timescale 1ns/10ps
`include "pmp_params.svh"
module pmp_port_logic_test;
    logic        core_clk_i, sys_rst_i, mode_select_low_i, mode_select_high_i;
    logic        reg_wr_i, reg_rd_i, bus_read_i, bus_active_i, expanded_o, nrm;
    logic        port_b_pull_en_o, port_f_pull_en_o, port_g_pull_en_o;
    logic [15:0] bus_addr_i;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, bus_wdata_i, bus_rdata_o, v, cexp, hoe;
    logic [7:0]  port_e_pin_i, port_e_adc_o, port_h_pull_en_o, port_h_pull_up_o, dexp;
    logic [7:0]  port_a_alt_en_i, port_a_alt_out_i, port_a_alt_oe_i, port_a_alt_in_o;
    logic [7:0]  port_h_alt_en_i, port_h_alt_out_i, port_h_alt_oe_i, port_h_alt_in_o;
    logic [5:0]  port_d_alt_en_i, port_d_alt_out_i, port_d_alt_oe_i, port_d_alt_in_o;
    logic [53:0] p_o, p_oe, p_i, ext;
    logic [7:0]  ofs [7];
    logic [1:0]  md;
    int          seed = 33102;
    int          n_fail = 0;
    int          n_checks = 0;
    int          cyc = 0;

    // Pin slices: A 53:46, B 45:38, C 37:30, D 29:24, F 23:16, G 15:8, H 7:0.
    pmp_port_logic i_pmp_port_logic (.*,
        .port_a_pin_i(p_i[53:46]), .port_a_pin_o(p_o[53:46]), .port_a_pin_oe_o(p_oe[53:46]),
        .port_b_pin_i(p_i[45:38]), .port_b_pin_o(p_o[45:38]), .port_b_pin_oe_o(p_oe[45:38]),
        .port_c_pin_i(p_i[37:30]), .port_c_pin_o(p_o[37:30]), .port_c_pin_oe_o(p_oe[37:30]),
        .port_d_pin_i(p_i[29:24]), .port_d_pin_o(p_o[29:24]), .port_d_pin_oe_o(p_oe[29:24]),
        .port_f_pin_i(p_i[23:16]), .port_f_pin_o(p_o[23:16]), .port_f_pin_oe_o(p_oe[23:16]),
        .port_g_pin_i(p_i[15:8]), .port_g_pin_o(p_o[15:8]), .port_g_pin_oe_o(p_oe[15:8]),
        .port_h_pin_i(p_i[7:0]), .port_h_pin_o(p_o[7:0]), .port_h_pin_oe_o(p_oe[7:0]));
    pmp_pin_model #(.W(54)) i_pmp_pin_model (.out_i(p_o), .oe_i(p_oe), .ext_i(ext), .pin_o(p_i));

    // Free-running 25 MHz core clock.
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // A hang is cut short well beyond the roughly three hundred cycles the run needs.
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    function automatic logic [7:0] mix(input logic [7:0] s, input logic [7:0] a,
                                       input logic [7:0] b);
        return (s & a) | (~s & b);
    endfunction : mix

    // Port C drive: bus data only on writes, open drain only in single chip mode.
    function automatic logic [7:0] c_oe_exp(input logic [1:0] m, input logic [7:0] d,
                                            input logic r);
        if (m[0]) return r ? 8'h00 : 8'hFF;
        return (m == 2'b10) ? ~d : 8'hFF;
    endfunction : c_oe_exp

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write

    // Read data are taken in the one cycle after the strobe.
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(name, exp, reg_rdata_o);
    endtask : rd_chk

    // Mode pins are held through reset, then moved to show they were latched.
    task automatic do_reset(input logic [1:0] m);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        {mode_select_high_i, mode_select_low_i} <= m;
        repeat (10) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        {mode_select_high_i, mode_select_low_i} <= ~m;
    endtask : do_reset

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // Each mode: reset, fill every direction and latch, then check pins and read-back.
    initial begin
        ofs = '{`PMP_OFS_A_LATCH, `PMP_OFS_B_LATCH, `PMP_OFS_C_LATCH, `PMP_OFS_D_LATCH,
                `PMP_OFS_F_LATCH, `PMP_OFS_G_LATCH, `PMP_OFS_H_LATCH};
        {sys_rst_i, mode_select_low_i, mode_select_high_i, reg_wr_i, reg_rd_i} = 5'h10;
        {reg_addr_i, reg_wdata_i, bus_addr_i, bus_wdata_i, bus_read_i, bus_active_i} = '0;
        {port_e_pin_i, port_a_alt_en_i, port_a_alt_out_i, port_a_alt_oe_i, ext} = '0;
        {port_h_alt_en_i, port_h_alt_out_i, port_h_alt_oe_i} = '0;
        {port_d_alt_en_i, port_d_alt_out_i, port_d_alt_oe_i} = '0;
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            nrm = ~md[0];
            do_reset(md);
            v = (m == 0) ? 8'hFF : 8'($random(seed));
            ext              <= 54'({$random(seed), $random(seed)});
            bus_addr_i       <= 16'($random(seed));
            bus_wdata_i      <= 8'($random(seed));
            bus_read_i       <= md[1];
            bus_active_i     <= 1'b1;
            port_e_pin_i     <= 8'($random(seed));
            port_a_alt_en_i  <= 8'($random(seed));
            port_a_alt_out_i <= 8'($random(seed));
            port_a_alt_oe_i  <= 8'hFF;
            port_d_alt_en_i  <= 6'($random(seed));
            port_d_alt_out_i <= 6'($random(seed));
            port_d_alt_oe_i  <= 6'h3F;
            port_h_alt_en_i  <= 8'($random(seed));
            port_h_alt_out_i <= 8'($random(seed));
            port_h_alt_oe_i  <= 8'hFF;
            @(posedge core_clk_i);
            rd_chk("mode", `PMP_OFS_MODE, 8'h01 << md);
            reg_write(`PMP_OFS_MODE, 8'h00);
            rd_chk("mode_ro", `PMP_OFS_MODE, 8'h01 << md);
            rd_chk("a_dir", `PMP_OFS_A_DIR, 8'h00);
            rd_chk("a_in", `PMP_OFS_A_LATCH,
                   mix(port_a_alt_en_i, port_a_alt_out_i, ext[53:46]));
            check("a_oe", port_a_alt_en_i, p_oe[53:46]);
            check("bus_mode", {7'h00, ~nrm}, {7'h00, expanded_o});
            reg_write(`PMP_OFS_OPTION, 8'h01);
            foreach (ofs[i]) begin
                reg_write(ofs[i] + 8'h01, 8'hFF);
                reg_write(ofs[i], v);
            end
            @(posedge core_clk_i);
            #1;
            cexp = mix(c_oe_exp(md, v, bus_read_i), nrm ? v : bus_wdata_i, ext[37:30]);
            hoe = mix(port_h_alt_en_i, 8'hFF, nrm ? 8'hFF : 8'h00);
            dexp = mix({2'h0, port_d_alt_en_i}, {2'h0, port_d_alt_out_i}, v & 8'h3F);
            check("a_pin", mix(port_a_alt_en_i, port_a_alt_out_i, v), p_o[53:46]);
            check("b_pin", nrm ? v : bus_addr_i[15:8], p_o[45:38]);
            check("b_oe", 8'hFF, p_oe[45:38]);
            check("c_oe", c_oe_exp(md, v, bus_read_i), p_oe[37:30]);
            check("c_bus", cexp, bus_rdata_o);
            check("d_pin", dexp, {2'h0, p_o[29:24]});
            check("f_pin", nrm ? v : bus_addr_i[7:0], p_o[23:16]);
            check("g_oe", nrm ? 8'hFF : 8'h80, p_oe[15:8]);
            check("g7", {7'h00, nrm ? v[7] : bus_read_i}, {7'h00, p_o[15]});
            check("h_oe", hoe, p_oe[7:0]);
            check("h_pin", mix(port_h_alt_en_i, port_h_alt_out_i, v) & hoe,
                  p_o[7:0] & hoe);
            rd_chk("b_rd", `PMP_OFS_B_LATCH, nrm ? v : bus_addr_i[15:8]);
            rd_chk("c_rd", `PMP_OFS_C_LATCH, cexp);
            rd_chk("d_rd", `PMP_OFS_D_LATCH, dexp);
            rd_chk("g_rd", `PMP_OFS_G_LATCH, nrm ? v : {bus_read_i, ext[14:8]});
            reg_write(`PMP_OFS_E_PINS, 8'h5A);
            rd_chk("e_rd", `PMP_OFS_E_PINS, port_e_pin_i);
            reg_write(`PMP_OFS_PULL_BFG, 8'h07);
            reg_write(`PMP_OFS_PULL_H, v);
            @(posedge core_clk_i);
            #1;
            check("pull_bfg", 8'h07,
                  {5'h00, port_g_pull_en_o, port_f_pull_en_o, port_b_pull_en_o});
            check("pull_h", v, port_h_pull_en_o);
            check("pull_up", 8'hF0, port_h_pull_up_o);
            rd_chk("unmapped", 8'h7F, 8'h00);
            reg_write(`PMP_OFS_A_LATCH, ~v);
            @(posedge core_clk_i);
            bus_active_i <= 1'b0;
            #1;
            check("c_idle", c_oe_exp(md, v, 1'b1), p_oe[37:30]);
            check("a_keep", mix(port_a_alt_en_i, port_a_alt_out_i, ~v), p_o[53:46]);
            $display("mode %0d test done", m);
        end
        end_of_test();
    end
endmodule : pmp_port_logic_test
